// ===== design/acs_consts.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * converter sequencer.
 * Assumes inclusion by bare name from design files compiled after it.
 */
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

// ****************************************************************
// Register byte offsets on the APB bus.
// ****************************************************************
`define ACS_OFF_CTRL0       8'h00
`define ACS_OFF_CTRL1       8'h04
`define ACS_OFF_CTRL2       8'h08
`define ACS_OFF_RESH        8'h0c
`define ACS_OFF_RESL        8'h10
`define ACS_OFF_INTC        8'h14

// ****************************************************************
// Field positions.
// ****************************************************************
`define ACS_C0_START        7
`define ACS_C0_BUSY         6
`define ACS_C0_PWR          5
`define ACS_C0_CH_LSB       0
`define ACS_C1_INS_LSB      4
`define ACS_C1_DIV_LSB      0
`define ACS_C2_FMT          7
`define ACS_C2_AMPIN        4
`define ACS_C2_REF_LSB      2
`define ACS_C2_GAIN_LSB     0
`define ACS_IC_GIE          0
`define ACS_IC_CIE          1
`define ACS_IC_FLAG         2

// ****************************************************************
// Reset values and timing counts.
// ****************************************************************
`define ACS_RST_BYTE        8'h00
`define ACS_SAMPLE_TICKS    3'd4
`define ACS_CONV_TICKS      4'd12
`define ACS_RES_MSB         4'd11

`endif

// ===== design/acs_pkg.sv
/*
 * Types shared by the converter sequencer files.
 * Assumes nothing of its surroundings.
 */
package acs_pkg;

    // Sequencer states, one-hot.
    typedef enum logic [2:0] {
        ACS_IDLE = 3'b001,
        ACS_SAMP = 3'b010,
        ACS_CONV = 3'b100
    } acs_state_t;

endpackage

// ===== design/acs_clkdiv.sv
/*
 * Converter clock divider: one tick every 2**sel system clocks.
 * Assumes sel is a registered field on the same clock and clr restarts the
 * phase so that a conversion begins on a full converter clock period.
 */
`timescale 1ns/10ps
`default_nettype none

module acs_clkdiv (
    // Clock, reset and enable.
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    // Control.
    input  wire logic       clr,
    input  wire logic [2:0] sel,
    // Converter clock tick.
    output logic            tick
);

    logic [6:0] cnt_q;
    logic [6:0] cnt_d;
    logic [6:0] mask;

    // Terminal count is 2**sel - 1; 000 ticks every cycle, 111 every 128.
    assign mask  = 7'((8'h01 << sel) - 8'h01);
    assign tick  = ce && !clr && (cnt_q == mask); // RQ7
    assign cnt_d = (clr || tick) ? 7'h00 : 7'(cnt_q + 7'h01);

    // Phase counter.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 7'h00;
        end else if (ce) begin
            cnt_q <= cnt_d;
        end
    end

    // A tick only ever falls at the selected terminal count.
    property p_div_period;
        @(posedge clk) disable iff (!rst_n)
        tick |-> (cnt_q == mask) && (cnt_q <= 7'h7f);
    endproperty
    a_div_period: assert property (p_div_period) else $error("divider tick off period"); // RQ7

endmodule

`default_nettype wire

// ===== design/acs_sequencer.sv
/*
 * Converter conversion sequencer with APB register file.
 * Assumes an APB master on MCLK and a comparator macro on MCLK that
 * answers the trial code in ADC_DAC within the same cycle.
 */
// How it works
// RQ1: Start bit low-high-low begins a conversion.
// RQ2: Busy flag set once conversion starts.
// RQ3: Busy flag clears when conversion finishes.
// RQ4: End of conversion sets the request flag.
// RQ5: Interrupt needs both global and converter enables.
// RQ6: Software may poll busy instead of interrupts.
// RQ7: Converter clock is system clock over 2**select.
// RQ8: Software keeps converter clock period in range.
// RQ9: Converter powered only while power enable high.
// RQ10: Software waits settling after power enable.
// RQ11: Software clears power enable when unused.
// RQ12: Four sample ticks then twelve conversion ticks.
// RQ13: Bus stays serviced while converting.
// RQ14: Codes 0000, 0100, 11xx pick external channel.
// RQ15: Internal codes disconnect the external channel.
// RQ16: Software configures the shared pin function.
// RQ17: Format bit arranges result across bytes.
// RQ18: Amplifier settings apply only with amplified reference.
// RQ19: Finished result held in result byte registers.
// RQ20: Software configures everything before the start.
// RQ21: Result is twelve bits, all ones full scale.
// RQ22: Reference codes: supply, pin, amplifier output.
// RQ23: Left or right alignment, unused bits zero.
// RQ24: Start while busy restarts the conversion.
`timescale 1ns/10ps
`default_nettype none

`include "acs_consts.svh"

module acs_sequencer (
    // Clock, reset and enable.
    input  wire logic        MCLK,
    input  wire logic        NRST,
    input  wire logic        CE,
    // APB slave.
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Analog macro control.
    input  wire logic        ADC_COMP,
    output logic             ADC_PWR_EN,
    output logic             ADC_SAMPLE,
    output logic [11:0]      ADC_DAC,
    output logic             ADC_EXT_EN,
    output logic [3:0]       ADC_CH_SEL,
    output logic [3:0]       ADC_INT_SEL,
    output logic [1:0]       ADC_REF_SEL,
    output logic             ADC_AMP_EN,
    output logic             ADC_AMP_IN,
    output logic [1:0]       ADC_AMP_GAIN,
    // Interrupt request toward the converter vector.
    output logic             IRQ
);

    // ****************************************************************
    // Bus decode.
    // ****************************************************************
    logic       acc_first;
    logic       wr_en;
    logic       rd_cap;
    logic       hit_c0;
    logic       hit_c1;
    logic       hit_c2;
    logic       hit_rh;
    logic       hit_rl;
    logic       hit_ic;
    logic       hit_any;
    logic [7:0] rd_byte;

    // One wait state: ready rises the cycle after the access phase begins.
    assign acc_first = PSEL && PENABLE && !PREADY;
    assign wr_en     = PSEL && PENABLE && PREADY && PWRITE;
    assign rd_cap    = acc_first && !PWRITE;
    assign hit_c0    = (PADDR == `ACS_OFF_CTRL0);
    assign hit_c1    = (PADDR == `ACS_OFF_CTRL1);
    assign hit_c2    = (PADDR == `ACS_OFF_CTRL2);
    assign hit_rh    = (PADDR == `ACS_OFF_RESH);
    assign hit_rl    = (PADDR == `ACS_OFF_RESL);
    assign hit_ic    = (PADDR == `ACS_OFF_INTC);
    assign hit_any   = hit_c0 || hit_c1 || hit_c2 || hit_rh || hit_rl || hit_ic;

    // ****************************************************************
    // Control registers.
    // ****************************************************************
    logic        start_q;
    logic        pwr_q;
    logic [3:0]  ch_q;
    logic [3:0]  ins_q;
    logic [2:0]  div_q;
    logic        fmt_q;
    logic        ampin_q;
    logic [1:0]  ref_q;
    logic [1:0]  gain_q;
    logic        gie_q;
    logic        cie_q;

    // Software-written fields; busy and the result are read-only.
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            start_q <= 1'b0;
            pwr_q   <= 1'b0;
            ch_q    <= 4'h0;
            ins_q   <= 4'h0;
            div_q   <= 3'h0;
            fmt_q   <= 1'b0;
            ampin_q <= 1'b0;
            ref_q   <= 2'h0;
            gain_q  <= 2'h0;
            gie_q   <= 1'b0;
            cie_q   <= 1'b0;
        end else if (CE && wr_en) begin
            if (hit_c0) begin
                start_q <= PWDATA[`ACS_C0_START];
                pwr_q   <= PWDATA[`ACS_C0_PWR];
                ch_q    <= PWDATA[`ACS_C0_CH_LSB +: 4];
            end
            if (hit_c1) begin
                ins_q <= PWDATA[`ACS_C1_INS_LSB +: 4];
                div_q <= PWDATA[`ACS_C1_DIV_LSB +: 3];
            end
            if (hit_c2) begin
                fmt_q   <= PWDATA[`ACS_C2_FMT];
                ampin_q <= PWDATA[`ACS_C2_AMPIN];
                ref_q   <= PWDATA[`ACS_C2_REF_LSB +: 2];
                gain_q  <= PWDATA[`ACS_C2_GAIN_LSB +: 2];
            end
            if (hit_ic) begin
                gie_q <= PWDATA[`ACS_IC_GIE];
                cie_q <= PWDATA[`ACS_IC_CIE];
            end
        end
    end

    // ****************************************************************
    // Start detection and sequencing.
    // ****************************************************************
    acs_pkg::acs_state_t st_q;
    acs_pkg::acs_state_t st_d;
    logic                start_prev_q;
    logic                go;
    logic                tick;
    logic [2:0]          samp_q;
    logic [3:0]          bit_q;
    logic [11:0]         trial_q;
    logic [11:0]         trial_keep;
    logic [11:0]         trial_d;
    logic                conv_last;
    logic                busy_q;
    logic                flag_q;
    logic [11:0]         res_q;
    logic                flag_clr;

    // The falling edge of the start bit completes the low-high-low pulse;
    // an unpowered converter ignores it.
    assign go        = CE && start_prev_q && !start_q && pwr_q; // RQ1
    assign conv_last = (st_q == acs_pkg::ACS_CONV) && tick && (bit_q == 4'h0);
    assign flag_clr  = wr_en && hit_ic && !PWDATA[`ACS_IC_FLAG];

    // Successive approximation: keep the trial bit if the input is at or
    // above the trial code, then try the next lower bit.
    assign trial_keep = ADC_COMP ? trial_q : (trial_q & ~(12'h001 << bit_q)); // RQ21

    // The DAC shows the next trial code so that the comparator answers the
    // current one even when a tick falls on every cycle.
    assign trial_d = go ? 12'h800 :
                     (tick && st_q == acs_pkg::ACS_CONV && !conv_last) ?
                     (trial_keep | (12'h001 << (bit_q - 4'h1))) : trial_q;

    // Divider phase restarts on every start so sampling gets full periods.
    acs_clkdiv u_div (
        .clk   (MCLK),
        .rst_n (NRST),
        .ce    (CE),
        .clr   (go),
        .sel   (div_q),
        .tick  (tick)
    );

    // Next state; a fresh start wins over every other transition.
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            acs_pkg::ACS_IDLE: begin
                st_d = acs_pkg::ACS_IDLE;
            end
            acs_pkg::ACS_SAMP: begin
                if (tick && samp_q == `ACS_SAMPLE_TICKS - 3'd1) begin
                    st_d = acs_pkg::ACS_CONV; // RQ12
                end
            end
            acs_pkg::ACS_CONV: begin
                if (conv_last) begin
                    st_d = acs_pkg::ACS_IDLE;
                end
            end
            default: begin
                st_d = acs_pkg::ACS_IDLE;
            end
        endcase
        if (go) begin
            st_d = acs_pkg::ACS_SAMP; // RQ24
        end
        if (!pwr_q) begin
            st_d = acs_pkg::ACS_IDLE; // RQ9
        end
    end

    // Sequencer state, sample counter and trial code.
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            st_q         <= acs_pkg::ACS_IDLE;
            start_prev_q <= 1'b0;
            samp_q       <= 3'h0;
            bit_q        <= 4'h0;
            trial_q      <= 12'h000;
        end else if (CE) begin
            st_q         <= st_d;
            start_prev_q <= start_q;
            if (go) begin
                samp_q  <= 3'h0;
                bit_q   <= `ACS_RES_MSB;
                trial_q <= 12'h800;
            end else if (tick && st_q == acs_pkg::ACS_SAMP) begin
                samp_q <= 3'(samp_q + 3'h1);
            end else if (tick && st_q == acs_pkg::ACS_CONV && !conv_last) begin
                bit_q   <= 4'(bit_q - 4'h1);
                trial_q <= trial_keep | (12'h001 << (bit_q - 4'h1));
            end
        end
    end

    // Busy, request flag and result; hardware set beats software clear.
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            busy_q <= 1'b0;
            flag_q <= 1'b0;
            res_q  <= 12'h000;
        end else if (CE) begin
            busy_q <= (st_d != acs_pkg::ACS_IDLE); // RQ2 RQ3
            if (conv_last && !go) begin
                flag_q <= 1'b1; // RQ4
                res_q  <= trial_keep; // RQ19
            end else if (flag_clr) begin
                flag_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Read path and outputs.
    // ****************************************************************
    logic [7:0] res_hi;
    logic [7:0] res_lo;
    logic       ext_sel;

    // Format 0 left-aligns, format 1 right-aligns; spare bits read zero.
    assign res_hi  = fmt_q ? {4'h0, res_q[11:8]} : res_q[11:4]; // RQ17 RQ23
    assign res_lo  = fmt_q ? res_q[7:0] : {res_q[3:0], 4'h0}; // RQ23
    assign ext_sel = (ins_q[1:0] == 2'b00 && !ins_q[3]) || (ins_q[3:2] == 2'b11); // RQ14 RQ15
    assign rd_byte = hit_c0 ? {1'b0, busy_q, pwr_q, 1'b0, ch_q} :
                     hit_c1 ? {ins_q, 1'b0, div_q} :
                     hit_c2 ? {fmt_q, 2'b00, ampin_q, ref_q, gain_q} :
                     hit_rh ? res_hi :
                     hit_rl ? res_lo :
                     hit_ic ? {5'h00, flag_q, cie_q, gie_q} : `ACS_RST_BYTE;

    // Bus answer; one fixed wait state whatever the sequencer is doing, so software runs on.
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end else if (CE) begin
            PREADY  <= acc_first; // RQ13
            PSLVERR <= acc_first && !hit_any;
            if (rd_cap) begin
                PRDATA <= {24'h00_0000, rd_byte};
            end
        end
    end

    // Analog-side controls, all registered.
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            ADC_PWR_EN   <= 1'b0;
            ADC_SAMPLE   <= 1'b0;
            ADC_DAC      <= 12'h000;
            ADC_EXT_EN   <= 1'b0;
            ADC_CH_SEL   <= 4'h0;
            ADC_INT_SEL  <= 4'h0;
            ADC_REF_SEL  <= 2'h0;
            ADC_AMP_EN   <= 1'b0;
            ADC_AMP_IN   <= 1'b0;
            ADC_AMP_GAIN <= 2'h0;
            IRQ          <= 1'b0;
        end else if (CE) begin
            ADC_PWR_EN   <= pwr_q; // RQ9
            ADC_SAMPLE   <= (st_d == acs_pkg::ACS_SAMP);
            ADC_DAC      <= trial_d;
            ADC_EXT_EN   <= ext_sel && pwr_q;
            ADC_CH_SEL   <= ch_q;
            ADC_INT_SEL  <= ins_q;
            ADC_REF_SEL  <= ref_q; // RQ22
            // Amplifier settings are masked unless its output is the reference.
            ADC_AMP_EN   <= ref_q[1]; // RQ18
            ADC_AMP_IN   <= ref_q[1] && ampin_q;
            ADC_AMP_GAIN <= ref_q[1] ? gain_q : 2'h0;
            IRQ          <= flag_q && gie_q && cie_q; // RQ5
        end
    end

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    property p_start_busy;
        @(posedge MCLK) disable iff (!NRST)
        go |=> busy_q && st_q == acs_pkg::ACS_SAMP;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("start not taken"); // RQ2

    property p_done;
        @(posedge MCLK) disable iff (!NRST)
        conv_last && !go && pwr_q |=> !busy_q && flag_q;
    endproperty
    a_done: assert property (p_done) else $error("end of conversion missed"); // RQ3

    property p_samp_len;
        @(posedge MCLK) disable iff (!NRST)
        $rose(st_q == acs_pkg::ACS_CONV) |-> $past(samp_q) == 3'd3;
    endproperty
    a_samp_len: assert property (p_samp_len) else $error("sample phase length wrong"); // RQ12

    property p_irq_gate;
        @(posedge MCLK) disable iff (!NRST)
        CE && flag_q && gie_q && cie_q |=> IRQ;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt not raised"); // RQ5

    property p_irq_off;
        @(posedge MCLK) disable iff (!NRST)
        IRQ |-> $past(gie_q) && $past(cie_q) && $past(flag_q);
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt without enables"); // RQ5

    property p_ext_off;
        @(posedge MCLK) disable iff (!NRST)
        CE && !ins_q[3] && ins_q[1:0] != 2'b00 |=> !ADC_EXT_EN;
    endproperty
    a_ext_off: assert property (p_ext_off) else $error("external channel left on"); // RQ15

    property p_pwr_idle;
        @(posedge MCLK) disable iff (!NRST)
        CE && !pwr_q |=> !busy_q && !ADC_PWR_EN;
    endproperty
    a_pwr_idle: assert property (p_pwr_idle) else $error("unpowered converter active"); // RQ9

    property p_hold;
        @(posedge MCLK) disable iff (!NRST)
        !conv_last |=> $stable(res_q);
    endproperty
    a_hold: assert property (p_hold) else $error("result changed while held"); // RQ19

    property p_fmt_right;
        @(posedge MCLK) disable iff (!NRST)
        CE && rd_cap && hit_rh && fmt_q |=> PRDATA[31:4] == 28'h000_0000;
    endproperty
    a_fmt_right: assert property (p_fmt_right) else $error("spare result bits set"); // RQ23

    property p_restart;
        @(posedge MCLK) disable iff (!NRST)
        go && busy_q |=> !$changed(flag_q) || !flag_q;
    endproperty
    a_restart: assert property (p_restart) else $error("aborted conversion flagged"); // RQ24

    c_conv_done: cover property (@(posedge MCLK) disable iff (!NRST) conv_last);
    c_restart: cover property (@(posedge MCLK) disable iff (!NRST) go && busy_q);
    c_irq: cover property (@(posedge MCLK) disable iff (!NRST) $rose(IRQ));

endmodule

`default_nettype wire

// ===== verification/acs_sequencer_tb_top.sv
/*
 * Self-checking bench for the converter sequencer: APB master, comparator
 * stand-in and result checks.
 * Assumes the design package and files are compiled first; the bench plays
 * an ideal comparator so the result must equal the analog code it holds.
 */
`timescale 1ns/10ps
`default_nettype none

`include "acs_consts.svh"

module acs_sequencer_tb_top;

    // ****************************************************************
    // Design ports and bench state.
    // ****************************************************************
    logic        MCLK = 1'b0;
    logic        NRST = 1'b0;
    logic        CE = 1'b1;
    logic        PSEL = 1'b0;
    logic        PENABLE = 1'b0;
    logic        PWRITE = 1'b0;
    logic [7:0]  PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h00000000;
    logic [31:0] PRDATA;
    logic        PREADY;
    logic        PSLVERR;
    wire logic   ADC_COMP;
    logic        ADC_PWR_EN;
    logic        ADC_SAMPLE;
    logic [11:0] ADC_DAC;
    logic        ADC_EXT_EN;
    logic [3:0]  ADC_CH_SEL;
    logic [3:0]  ADC_INT_SEL;
    logic [1:0]  ADC_REF_SEL;
    logic        ADC_AMP_EN;
    logic        ADC_AMP_IN;
    logic [1:0]  ADC_AMP_GAIN;
    logic        IRQ;
    logic [11:0] ain_q = 12'h000;
    logic [31:0] rd;
    logic        err;
    logic [31:0] seed;
    int          n_mismatch = 0;
    int          total_checks = 0;
    int          samp_cnt = 0;

    always #25 MCLK = ~MCLK;

    // Ideal comparator: the trial code wins when it does not exceed the input.
    assign ADC_COMP = (ain_q >= ADC_DAC);

    // Sample-phase length is measured here so no bus poll can miss a cycle.
    always @(posedge MCLK) begin
        if (ADC_SAMPLE === 1'b1) begin
            samp_cnt++;
        end
    end

    acs_sequencer DUT (
        .MCLK(MCLK), .NRST(NRST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .ADC_COMP(ADC_COMP),
        .ADC_PWR_EN(ADC_PWR_EN), .ADC_SAMPLE(ADC_SAMPLE), .ADC_DAC(ADC_DAC),
        .ADC_EXT_EN(ADC_EXT_EN), .ADC_CH_SEL(ADC_CH_SEL), .ADC_INT_SEL(ADC_INT_SEL),
        .ADC_REF_SEL(ADC_REF_SEL), .ADC_AMP_EN(ADC_AMP_EN), .ADC_AMP_IN(ADC_AMP_IN),
        .ADC_AMP_GAIN(ADC_AMP_GAIN), .IRQ(IRQ)
    );

    // ****************************************************************
    // Helpers.
    // ****************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h00000000);
    endfunction

    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic hang(input string what);
        n_mismatch++;
        $display("ERROR t=%0t wait ran out: %s", $time, what);
        report_and_stop();
    endtask

    // One APB transfer; an edge always passes first so no signal is set twice at once.
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge MCLK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= w;
        PADDR   <= a;
        PWDATA  <= {24'h000000, d};
        @(posedge MCLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge MCLK);
            n++;
        end while (PREADY !== 1'b1 && n < 16);
        if (PREADY !== 1'b1) begin
            hang("bus ready");
        end
        // Data and error are taken at the ready edge itself, then released.
        rd  = PRDATA;
        err = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic pulse(input logic [3:0] ch);
        bus(1'b1, `ACS_OFF_CTRL0, {3'b101, 1'b0, ch});
        bus(1'b1, `ACS_OFF_CTRL0, {3'b001, 1'b0, ch});
    endtask

    // ****************************************************************
    // One conversion, optionally restarted in mid-flight.
    // ****************************************************************
    task automatic conv(input logic [2:0] div, input logic fmt, input logic ie,
                        input logic [11:0] ain, input logic rs);
        logic [3:0]  ch;
        logic [15:0] res;
        int          p;
        int          n;
        p     = 1 << div;
        ch    = ain[3:0];
        ain_q <= ain;
        bus(1'b1, `ACS_OFF_CTRL1, {5'h00, div});
        // The shared pin is taken as already set to converter input.
        bus(1'b1, `ACS_OFF_CTRL0, {3'b001, 1'b0, ch});
        bus(1'b1, `ACS_OFF_CTRL2, {fmt, 7'h00});
        bus(1'b1, `ACS_OFF_INTC, {6'h00, ie, ie});
        repeat (8) @(posedge MCLK);
        samp_cnt = 0;
        pulse(ch);
        if (rs) begin
            repeat (30) @(posedge MCLK);
            samp_cnt = 0;
            pulse(ch);
            repeat (40) @(posedge MCLK);
            bus(1'b0, `ACS_OFF_INTC, 8'h00);
            chk(rd[2], 1'b0, "flag of aborted run");
        end
        bus(1'b0, `ACS_OFF_CTRL0, 8'h00);
        chk(rd, {24'h000000, 3'b011, 1'b0, ch}, "busy after start");
        n = 0;
        do begin
            bus(1'b0, `ACS_OFF_CTRL0, 8'h00);
            n++;
        end while (rd[6] !== 1'b0 && n < 1000);
        if (rd[6] !== 1'b0) begin
            hang("busy clear");
        end
        chk(samp_cnt >= 4 * p - 1 && samp_cnt <= 4 * p + 1, 1'b1, "sample length");
        res = fmt ? {4'h0, ain} : {ain, 4'h0};
        bus(1'b0, `ACS_OFF_RESH, 8'h00);
        chk(rd, {24'h000000, res[15:8]}, "result high");
        bus(1'b0, `ACS_OFF_RESL, 8'h00);
        chk(rd, {24'h000000, res[7:0]}, "result low");
        bus(1'b0, `ACS_OFF_INTC, 8'h00);
        chk(rd[2], 1'b1, "end flag");
        @(negedge MCLK);
        chk(IRQ, ie, "request line");
        bus(1'b1, `ACS_OFF_INTC, {6'h00, ie, ie});
        @(posedge MCLK);
        @(negedge MCLK);
        chk(IRQ, 1'b0, "request after clear");
        $display("Test conversion div %0d done", div);
    endtask

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        seed = 32'h6b47;
        repeat (4) @(posedge MCLK);
        NRST <= 1'b1;
        // Every register starts at zero; the unmapped word is refused.
        for (int a = 0; a < 6; a++) begin
            bus(1'b0, 8'(a * 4), 8'h00);
            chk(rd, 32'h0, "reset value");
        end
        bus(1'b1, 8'h18, 8'hff);
        chk(err, 1'b1, "unmapped write");
        bus(1'b0, 8'h18, 8'h00);
        chk(err, 1'b1, "unmapped read error");
        chk(rd, 32'h0, "unmapped read data");
        $display("Test reset and map done");
        // Input routing over every internal select code, powered.
        bus(1'b1, `ACS_OFF_CTRL0, 8'h69);
        bus(1'b0, `ACS_OFF_CTRL0, 8'h00);
        chk(rd, 32'h29, "busy is read only");
        for (int i = 0; i < 16; i++) begin
            bus(1'b1, `ACS_OFF_CTRL1, {i[3:0], 4'h0});
            repeat (2) @(negedge MCLK);
            chk({ADC_INT_SEL, ADC_CH_SEL}, {i[3:0], 4'h9}, "select copies");
            chk(ADC_EXT_EN, (i == 0 || i == 4 || i >= 12), "external path");
        end
        for (int r = 0; r < 4; r++) begin
            bus(1'b1, `ACS_OFF_CTRL2, {3'b000, 1'b1, r[1:0], 2'b11});
            repeat (2) @(negedge MCLK);
            chk(ADC_REF_SEL, r[1:0], "reference");
            chk({ADC_AMP_EN, ADC_AMP_IN, ADC_AMP_GAIN}, r[1] ? 4'hf : 4'h0, "amp");
        end
        // Unpowered: path cut and a start pulse is ignored.
        bus(1'b1, `ACS_OFF_CTRL1, 8'h00);
        bus(1'b1, `ACS_OFF_CTRL0, 8'h89);
        bus(1'b1, `ACS_OFF_CTRL0, 8'h09);
        bus(1'b0, `ACS_OFF_CTRL0, 8'h00);
        chk(rd, 32'h09, "no busy unpowered");
        chk({ADC_PWR_EN, ADC_EXT_EN}, 2'b00, "power off");
        $display("Test routing and power done");
        // Corner cases on dividers 0 to 3, then random conversions on dividers 4 to 7.
        conv(3'd0, 1'b0, 1'b1, 12'hfff, 1'b0);
        conv(3'd1, 1'b1, 1'b0, 12'h000, 1'b0);
        conv(3'd2, 1'b1, 1'b1, 12'h5a3, 1'b1);
        conv(3'd3, 1'b0, 1'b1, 12'h801, 1'b0);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            conv({1'b1, i[1:0]}, seed[12], seed[13], seed[11:0], 1'b0);
        end
        // Power the converter down once it is no longer needed.
        bus(1'b1, `ACS_OFF_CTRL0, 8'h00);
        repeat (2) @(negedge MCLK);
        chk(ADC_PWR_EN, 1'b0, "power dropped");
        report_and_stop();
    end

endmodule

`default_nettype wire
